//--- acp_port.sv
// Control and result port of a 16-bit successive-approximation converter
`timescale 1ns/100ps
`default_nettype none
// ********************************************************************
// Function
// ********************************************************************
module acp_port
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Host control lines
    input wire acp_pkg::acp_ctrl_t ctrl,
    // Converter core sample, two's complement
    input wire logic [acp_pkg::ACP_DATA_W-1:0] sample,
    // Result bus and busy
    output acp_pkg::acp_bus_t bus,
    output logic busy_n
);
    import acp_pkg::*;

    // ****************************************************************
    // Control edge detection
    // ****************************************************************
    logic start_n_reg;
    logic start_n_next;
    logic start_fall;
    // Combined active-low start line; conversion begins when it falls
    always_comb
    begin
        start_n_next = ctrl.cs_n | ctrl.rc_n;
        start_fall = start_n_reg & ~start_n_next;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            start_n_reg <= 1'b1;
        end
        else
        begin
            start_n_reg <= start_n_next;
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    acp_state_t state_reg;
    acp_state_t state_next;
    logic [ACP_CNT_W-1:0] count_reg;
    logic [ACP_CNT_W-1:0] count_next;
    logic [ACP_DATA_W-1:0] hold_reg;
    logic [ACP_DATA_W-1:0] hold_next;
    logic [ACP_DATA_W-1:0] result_reg;
    logic [ACP_DATA_W-1:0] result_next;
    logic busy_n_reg;
    logic busy_n_next;

    // Sample held on start; result loaded one cycle before busy releases
    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg;
        hold_next = hold_reg;
        result_next = result_reg;
        busy_n_next = busy_n_reg;
        unique case (state_reg)
            ACP_IDLE:
            begin
                if (start_fall)
                begin
                    hold_next = sample;
                    count_next = '0;
                    busy_n_next = 1'b0;
                    state_next = ACP_CONVERT;
                end
            end
            ACP_CONVERT:
            begin
                // Starts during conversion are ignored here
                if (count_reg == ACP_CONV_LAST)
                begin
                    result_next = hold_reg;
                    state_next = ACP_IDLE;
                end
                else
                begin
                    count_next = count_reg + 1'b1;
                end
            end
        endcase
        // Busy rises the cycle after the result register is loaded
        if (state_reg == ACP_IDLE && !start_fall)
        begin
            busy_n_next = 1'b1;
        end
    end

    // Result register has a defined reset value; first result is
    // still meaningless to the host since no real sample preceded it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ACP_IDLE;
            count_reg <= '0;
            hold_reg <= ACP_SAMPLE_RST;
            result_reg <= ACP_RESULT_RST;
            busy_n_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
            hold_reg <= hold_next;
            result_reg <= result_next;
            busy_n_reg <= busy_n_next;
        end
    end

    // ****************************************************************
    // Result bus drivers
    // ****************************************************************
    logic [ACP_DATA_W-1:0] out_reg;
    logic [ACP_DATA_W-1:0] out_next;
    logic drive;
    // Output enable is combinational from the pins so the bus floats
    // the moment either line leaves the read condition
    always_comb
    begin
        drive = ~ctrl.cs_n & ctrl.rc_n;
        if (ctrl.half_swap)
        begin
            out_next = {result_reg[ACP_HALF_W-1:0],
                result_reg[ACP_DATA_W-1:ACP_HALF_W]};
        end
        else
        begin
            out_next = result_reg;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            out_reg <= ACP_RESULT_RST;
        end
        else
        begin
            out_reg <= out_next;
        end
    end

    always_comb
    begin
        bus.data = out_reg;
        bus.oe_n = {ACP_DATA_W{~drive}};
        busy_n = busy_n_reg;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    busy_on_start_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ACP_IDLE && start_fall) |=> !busy_n)
        else $error("busy not asserted on start");
    float_when_idle_a: assert property (@(posedge clk) disable iff (reset)
        (ctrl.cs_n || !ctrl.rc_n) |-> (bus.oe_n == '1))
        else $error("bus driven while deselected");
    drive_on_read_a: assert property (@(posedge clk) disable iff (reset)
        (!ctrl.cs_n && ctrl.rc_n) |-> (bus.oe_n == '0))
        else $error("bus not driven during read");
    swap_order_a: assert property (@(posedge clk) disable iff (reset)
        ctrl.half_swap |=> (bus.data == {$past(result_reg[7:0]),
        $past(result_reg[15:8])}))
        else $error("half swap order wrong");
    plain_order_a: assert property (@(posedge clk) disable iff (reset)
        !ctrl.half_swap |=> (bus.data == $past(result_reg)))
        else $error("natural order wrong");
    result_before_busy_a: assert property (@(posedge clk)
        disable iff (reset)
        $rose(busy_n) |-> $past(result_reg) == $past(hold_reg, 2))
        else $error("result not loaded before busy release");
    ignore_starts_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ACP_CONVERT && start_fall) |=> $stable(hold_reg))
        else $error("start accepted during conversion");
    busy_length_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ACP_IDLE && start_fall) |=> !busy_n [*8])
        else $error("busy released too early");
    data_at_busy_a: assert property (@(posedge clk) disable iff (reset)
        $rose(busy_n) && !ctrl.half_swap |-> bus.data == result_reg)
        else $error("data not valid at busy rise");

    // ****************************************************************
    // Check helpers
    // ****************************************************************
    // Busy window length counted in logic, since a repetition count of
    // eight hundred and one would choke the property engine; cleared on every
    // accepted start so back to back conversions measure alike
    localparam logic [ACP_CNT_W-1:0] BUSY_LEN =
        ACP_CNT_W'(ACP_CONV_CYCLES + 1);
    logic [ACP_CNT_W-1:0] low_len_reg;
    logic [ACP_CNT_W-1:0] low_len_next;
    logic accept;

    // Count busy low cycles, saturating so the bound check cannot wrap
    always_comb
    begin
        accept = (state_reg == ACP_IDLE) && start_fall;
        low_len_next = '0;
        if (accept)
        begin
            low_len_next = '0;
        end
        else if (!busy_n_reg && low_len_reg != '1)
        begin
            low_len_next = low_len_reg + 1'b1;
        end
        else if (!busy_n_reg)
        begin
            low_len_next = low_len_reg;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            low_len_reg <= '0;
        end
        else
        begin
            low_len_reg <= low_len_next;
        end
    end

    // ****************************************************************
    // Sequencer checks
    // ****************************************************************
    // Busy must stand for the whole fixed count, not merely eight cycles
    busy_window_a: assert property (@(posedge clk) disable iff (reset)
        $rose(busy_n) |-> (low_len_reg == BUSY_LEN))
        else $error("busy window length wrong");
    // A stuck sequencer would hold busy low forever
    busy_bound_a: assert property (@(posedge clk) disable iff (reset)
        low_len_reg <= BUSY_LEN)
        else $error("busy window too long");
    // Busy is low throughout the convert state
    convert_busy_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ACP_CONVERT) |-> !busy_n)
        else $error("busy high while converting");
    // Counter never runs past its last value
    count_range_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ACP_CONVERT) |-> (count_reg <= ACP_CONV_LAST))
        else $error("conversion counter out of range");
    // Each convert cycle but the last advances the counter by one
    count_step_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ACP_CONVERT && count_reg != ACP_CONV_LAST)
        |=> (count_reg == $past(count_reg) + 1'b1))
        else $error("conversion counter skipped");
    // Accepted start enters convert with the counter cleared
    start_enter_a: assert property (@(posedge clk) disable iff (reset)
        accept |=> (state_reg == ACP_CONVERT && count_reg == '0))
        else $error("start not taken");
    // Sample is held at the start edge
    hold_capture_a: assert property (@(posedge clk) disable iff (reset)
        accept |=> (hold_reg == $past(sample)))
        else $error("sample not held on start");
    // Busy only falls because a start was accepted
    busy_fall_a: assert property (@(posedge clk) disable iff (reset)
        $fell(busy_n) |-> $past(accept))
        else $error("busy fell without a start");
    // Busy releases only from idle, after the sequencer finished
    release_idle_a: assert property (@(posedge clk) disable iff (reset)
        $rose(busy_n) |-> (state_reg == ACP_IDLE))
        else $error("busy released mid conversion");
    // Result register moves only at the end of a conversion
    result_quiet_a: assert property (@(posedge clk) disable iff (reset)
        !(state_reg == ACP_CONVERT && count_reg == ACP_CONV_LAST)
        |=> $stable(result_reg))
        else $error("result changed outside conversion end");
    // End of conversion copies the held sample into the result
    result_load_a: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ACP_CONVERT && count_reg == ACP_CONV_LAST)
        |=> (result_reg == $past(hold_reg)))
        else $error("result not loaded at conversion end");

    // ****************************************************************
    // Bus checks
    // ****************************************************************
    // Chip select high floats the bus whatever read/convert does
    chip_deselect_a: assert property (@(posedge clk) disable iff (reset)
        ctrl.cs_n |-> (bus.oe_n == '1))
        else $error("bus driven with chip select high");
    // Reads during a conversion still drive the bus
    read_in_busy_a: assert property (@(posedge clk) disable iff (reset)
        (!busy_n && !ctrl.cs_n && ctrl.rc_n) |-> (bus.oe_n == '0))
        else $error("read refused during conversion");
endmodule
`default_nettype wire

//--- acp_pkg.sv
// Package of constants and types for the converter read/convert port
package acp_pkg;
    // ****************************************************************
    // Widths and timing
    // ****************************************************************
    localparam int ACP_DATA_W = 16;
    localparam int ACP_HALF_W = 8;
    localparam int ACP_CLK_PERIOD_PS = 5000;
    // Conversion time in nanoseconds, longest allowed busy window; the port holds busy low 801 cycles, 4005 ns
    localparam int ACP_CONV_TIME_NS = 4000;
    // Longest time rounds down to whole cycles
    localparam int ACP_CONV_CYCLES = (ACP_CONV_TIME_NS * 1000)
        / ACP_CLK_PERIOD_PS;
    localparam int ACP_CNT_W = 10;
    localparam logic [ACP_CNT_W-1:0] ACP_CONV_LAST =
        ACP_CNT_W'(ACP_CONV_CYCLES - 1);
    // Least start pulse width held by the host, in ns and cycles
    localparam int ACP_START_PULSE_NS = 50;
    localparam int ACP_START_PULSE_CYCLES =
        (ACP_START_PULSE_NS * 1000 + ACP_CLK_PERIOD_PS - 1)
        / ACP_CLK_PERIOD_PS;
    // Reset values
    localparam logic [ACP_DATA_W-1:0] ACP_RESULT_RST = 16'h0000;
    localparam logic [ACP_DATA_W-1:0] ACP_SAMPLE_RST = 16'h0000;

    // Host control lines, all active low except the half swap select
    typedef struct packed {
        logic cs_n;
        logic rc_n;
        logic half_swap;
    } acp_ctrl_t;

    // Result bus pins: output value and output enable (low drives)
    typedef struct packed {
        logic [ACP_DATA_W-1:0] data;
        logic [ACP_DATA_W-1:0] oe_n;
    } acp_bus_t;

    typedef enum logic [0:0] {
        ACP_IDLE,
        ACP_CONVERT
    } acp_state_t;
endpackage

//--- acp_host.sv
// Host model driving the converter control lines
`timescale 1ns/100ps
`default_nettype none
module acp_host
(
    // Clock
    input wire logic clk,
    // Control lines
    output acp_pkg::acp_ctrl_t ctrl
);
    import acp_pkg::*;
    // ********
    // Strobes
    // ********
    // Deselected at rest, so nothing starts before the bench asks
    initial ctrl = '{1'b1, 1'b1, 1'b0};
    // All lines move together just after an edge
    task automatic set(input logic cs, rc, sw);
        @(posedge clk);
        ctrl <= '{cs, rc, sw};
    endtask
    // One line falls after the other is already low
    task automatic start(input logic via_cs);
        set(via_cs, ~via_cs, ctrl.half_swap);
        set(1'b0, 1'b0, ctrl.half_swap);
        repeat (ACP_START_PULSE_CYCLES - 1) @(posedge clk);
        set(1'b0, 1'b1, ctrl.half_swap);
    endtask
endmodule
`default_nettype wire

//--- acp_port_test.sv
// Testbench for the converter control and result port
`timescale 1ns/100ps
`default_nettype none
module acp_port_test;
    import acp_pkg::*;
    logic clk;
    logic reset;
    acp_ctrl_t ctrl;
    logic [ACP_DATA_W-1:0] sample;
    acp_bus_t bus;
    logic busy_n;
    int n_mismatch;
    int n_tests;
    int run = 0;
    int last_len = 0;
    // ********
    // Harness
    // ********
    acp_port acp_port_inst (.clk(clk), .reset(reset), .ctrl(ctrl),
        .sample(sample), .bus(bus), .busy_n(busy_n));
    acp_host acp_host_inst (.clk(clk), .ctrl(ctrl));
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Busy window length, kept once the window closes
    always @(posedge clk)
    begin
        run <= (busy_n === 1'b0) ? run + 1 : 0;
        last_len <= (busy_n !== 1'b0 && run != 0) ? run : last_len;
    end
    // Compare a bus word
    task automatic chk_word(input logic [ACP_DATA_W-1:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t word %h exp %h", $time, got, exp);
        end
    endtask
    // Compare a cycle count
    task automatic chk_cnt(input int got, exp);
        n_tests++;
        if (got != exp)
        begin
            n_mismatch++;
            $display("BAD %0t count %0d exp %0d", $time, got, exp);
        end
    endtask
    // Bounded wait on busy, sampled mid-cycle where it is settled
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 1000 && busy_n !== lvl; i++)
            @(negedge clk);
        if (busy_n !== lvl)
        begin
            n_mismatch++;
            $display("BAD %0t busy wait", $time);
            test_done;
        end
    endtask
    // Busy closes after a full conversion with the word in place
    task automatic end_conv(input logic [ACP_DATA_W-1:0] exp);
        wait_busy(1'b1);
        chk_word(bus.data, exp);
        chk_word(bus.oe_n, '0);
        @(negedge clk);
        chk_cnt(last_len, ACP_CONV_CYCLES + 1);
    endtask
    // Convert on read/convert falling, most positive code
    task automatic t_natural;
        @(posedge clk);
        sample <= 16'h7fff;
        acp_host_inst.start(1'b0);
        wait_busy(1'b0);
        end_conv(16'h7fff);
        $display("t_natural done");
    endtask
    // Convert on chip select falling, commands and reads mid-run
    task automatic t_swap;
        acp_host_inst.set(1'b1, 1'b1, 1'b1);
        sample <= 16'h8001;
        acp_host_inst.start(1'b1);
        wait_busy(1'b0);
        sample <= 16'h1234;
        acp_host_inst.start(1'b0);
        @(negedge clk);
        chk_word(bus.oe_n, '0);
        acp_host_inst.set(1'b1, 1'b1, 1'b1);
        @(negedge clk);
        chk_word(bus.oe_n, '1);
        acp_host_inst.set(1'b0, 1'b0, 1'b1);
        @(negedge clk);
        chk_word(bus.oe_n, '1);
        acp_host_inst.set(1'b0, 1'b1, 1'b1);
        end_conv(16'h0180);
        acp_host_inst.set(1'b0, 1'b1, 1'b0);
        repeat (2) @(negedge clk);
        chk_word(bus.data, 16'h8001);
        $display("t_swap done");
    endtask
    // Counts, verdict and end of run
    task automatic test_done;
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        reset = 1'b1;
        sample = '0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_natural;
        t_swap;
        test_done;
    end
endmodule
`default_nettype wire
